//--- hdl/oset_top.sv
// oset_top: oscillator ready status, manual force enable, fast oscillator frequency and trim
// Operation
// - oscillator ready flags at bits seven to two
// - pll ready needs enable, source ready, lock
// - manual bit forces on, clear never forces off
// - forced external runs in configured mode
// - forced fast oscillator runs at selected frequency
// - forced secondary runs in selected power mode
// - bit four forces low oscillator on
// - three bit code selects nominal fast frequency
// - frequency reset value follows reset source setting
// - six bit trim, centre code by default
// - frequency applies when fast source requested
// - power select one high, zero low
// assumes a classic wishbone master on mclk; ready and lock levels arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module oset_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // configuration straps and clock source request
    input wire logic [2:0] reset_clock_source_cfg,
    input wire logic [2:0] external_osc_mode_cfg,
    input wire logic [2:0] requested_clock_source,
    input wire logic secondary_power_select,
    // peripheral requests, index 0 is the conversion oscillator
    input wire logic [oset_pkg::OSET_NUM_OSC-1:0] periph_req,
    // asynchronous readiness from the oscillator macros
    input wire logic [oset_pkg::OSET_NUM_OSC-1:0] osc_ready_async,
    input wire logic pll_lock_async,
    // oscillator controls
    output oset_pkg::oset_osc_t osc_state,
    output logic pll_enable,
    output oset_pkg::oset_tune_t tune
);
    import oset_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [OSET_NUM_OSC-1:0] force_q;
    logic [2:0] freq_q;
    logic [5:0] trim_q;
    logic strap_done_q;
    logic [OSET_NUM_OSC-1:0] src_req;
    logic [OSET_NUM_OSC-1:0] run;
    logic [OSET_NUM_OSC:0] sync_lvl;
    logic [OSET_NUM_OSC-1:0] ready_s;
    logic lock_s;
    logic [7:0] status;
    logic [7:0] force_rd;
    logic bus_req;
    logic wr_lane0;
    logic adr_ok;
    logic ack_q;

    ////////////////////////////////////////////////////////////////////////////
    // readiness crossing; the pll lock level rides as the top bit of the same bus
    oset_sync #(.W(OSET_NUM_OSC + 1)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({pll_lock_async, osc_ready_async}),
        .sync_out(sync_lvl)
    );
    assign ready_s = sync_lvl[OSET_NUM_OSC-1:0];
    assign lock_s = sync_lvl[OSET_NUM_OSC];

    ////////////////////////////////////////////////////////////////////////////
    // clock source selection asks for the oscillator that feeds the system clock
    always_comb begin
        src_req = '0;
        pll_enable = 1'b0;
        case (requested_clock_source)
            OSET_SRC_EXT: src_req[OSET_BIT_EXT-OSET_OSC_LSB] = 1'b1;
            OSET_SRC_EXT_PLL: begin
                src_req[OSET_BIT_EXT-OSET_OSC_LSB] = 1'b1;
                pll_enable = 1'b1;
            end
            OSET_SRC_FAST_PLL: begin
                src_req[OSET_BIT_FAST-OSET_OSC_LSB] = 1'b1;
                pll_enable = 1'b1;
            end
            OSET_SRC_LOW: src_req[OSET_BIT_LOW-OSET_OSC_LSB] = 1'b1;
            OSET_SRC_SEC: src_req[OSET_BIT_SEC-OSET_OSC_LSB] = 1'b1;
            // reserved codes behave as the fast internal source
            default: src_req[OSET_BIT_FAST-OSET_OSC_LSB] = 1'b1;
        endcase
    end

    // the combined request is what keeps a macro alive
    oset_req u_req (
        .force_on(force_q),
        .periph_req(periph_req),
        .src_req(src_req),
        .run(run)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the oscillator macros
    // registered so the macros see clean levels, one edge behind the request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            osc_state <= '0;
            tune <= '0;
        end else begin
            osc_state.run <= run;
            osc_state.ready <= ready_s & run;
            tune.ext_mode <= external_osc_mode_cfg;
            tune.sec_high_power <= secondary_power_select;
            tune.fast_freq <= oset_freq_t'(freq_q);
            tune.fast_trim <= trim_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status: a macro ready level counts only while its oscillator is asked to run
    // trade-off: a stop clears the flag in the same cycle, a start waits for the
    // two synchroniser edges, so software never sees ready on a stopped source
    always_comb begin
        status = '0;
        status[OSET_BIT_EXT:OSET_OSC_LSB] = ready_s & run;
        status[OSET_PLL_BIT] = pll_enable & lock_s
            & ready_s[(requested_clock_source == OSET_SRC_EXT_PLL)
                ? (OSET_BIT_EXT - OSET_OSC_LSB) : (OSET_BIT_FAST - OSET_OSC_LSB)];
    end
    assign force_rd = {force_q, 2'b00} & OSET_FORCE_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode; one wait state, ack pulses once per request
    // err closes the request as ack does, or a held strobe would earn a second err
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_err_o;
    assign adr_ok = (wb_adr_i == OSET_ADDR_STATUS) | (wb_adr_i == OSET_ADDR_FORCE)
        | (wb_adr_i == OSET_ADDR_FREQ) | (wb_adr_i == OSET_ADDR_TRIM);
    assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0] & adr_ok;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            ack_q <= bus_req & adr_ok;
            wb_err_o <= bus_req & ~adr_ok; // unmapped address answers with err
        end
    end
    assign wb_ack_o = ack_q;

    // read data registered at request time, stable while ack stands
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_dat_o <= '0;
        end else if (bus_req) begin
            case (wb_adr_i)
                OSET_ADDR_STATUS: wb_dat_o <= {24'h000000, status};
                OSET_ADDR_FORCE: wb_dat_o <= {24'h000000, force_rd};
                OSET_ADDR_FREQ: wb_dat_o <= {29'h00000000, freq_q};
                OSET_ADDR_TRIM: wb_dat_o <= {26'h0000000, trim_q};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // force enable register, bits 1 and 0 not implemented
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            force_q <= OSET_FORCE_RST[OSET_BIT_EXT:OSET_OSC_LSB];
        end else if (wr_lane0 && wb_adr_i == OSET_ADDR_FORCE) begin
            force_q <= wb_dat_i[OSET_BIT_EXT:OSET_OSC_LSB];
        end
    end

    // trim register: centre code out of reset
    // every code is legal; the macro maps it monotonically around the centre
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trim_q <= OSET_TRIM_RST;
        end else if (wr_lane0 && wb_adr_i == OSET_ADDR_TRIM) begin
            trim_q <= wb_dat_i[5:0];
        end
    end

    // frequency code: strap sampled in the first clocked cycle after reset release,
    // since an async-free reset may still only load constants; the reserved code
    // is kept as written, the macro treats it as its own business
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_done_q <= 1'b0;
            freq_q <= OSET_FREQ_RST_1M;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            freq_q <= (reset_clock_source_cfg == OSET_SRC_FAST_32M)
                ? OSET_FREQ_RST_32M : OSET_FREQ_RST_1M;
        end else if (wr_lane0 && wb_adr_i == OSET_ADDR_FREQ) begin
            freq_q <= wb_dat_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks; antecedents that may start at the release edge also ask for a sampled
    // rst_n, because registers still show reset values one edge after release
    a_status_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(rst_n, 2) |-> status[OSET_BIT_EXT:OSET_OSC_LSB]
            == ($past(osc_ready_async, 2) & run))
        else $error("ready flag differs from the delayed oscillator level");
    a_pll_ready: assert property (@(posedge mclk) disable iff (!rst_n)
        status[OSET_PLL_BIT] |-> (pll_enable && lock_s))
        else $error("pll ready without enable and lock");
    a_force_runs: assert property (@(posedge mclk) disable iff (!rst_n)
        force_q[OSET_BIT_LOW-OSET_OSC_LSB] |=> osc_state.run[OSET_BIT_LOW-OSET_OSC_LSB])
        else $error("forced low oscillator not running");
    a_force_all: assert property (@(posedge mclk) disable iff (!rst_n)
        (|force_q) |=> ((osc_state.run & $past(force_q)) == $past(force_q)))
        else $error("forced oscillator not running");
    a_ext_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        rst_n |=> tune.ext_mode == $past(external_osc_mode_cfg))
        else $error("external mode not passed on");
    a_freq_out: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(freq_q) |=> tune.fast_freq == $past(freq_q))
        else $error("frequency code not applied");
    a_power_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && secondary_power_select) ##1 secondary_power_select |-> tune.sec_high_power)
        else $error("secondary power mode wrong");
    a_freq_strap: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && !strap_done_q && reset_clock_source_cfg == OSET_SRC_FAST_32M)
            |=> freq_q == OSET_FREQ_RST_32M)
        else $error("32 MHz reset code not loaded");
    a_ready_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        !run[0] |=> !osc_state.ready[0])
        else $error("ready kept after stop");
    a_ack_once: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    // bus answers
    a_err_once: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_err_o |=> !wb_err_o)
        else $error("err longer than one cycle");
    a_ack_err_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        !(wb_ack_o && wb_err_o))
        else $error("ack and err given together");
    // a refused access must leave the force and trim registers as they were
    a_err_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus_req && !adr_ok) |=> ($stable(force_q) && $stable(trim_q)))
        else $error("unmapped access changed a register");
    a_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("unused read data bits not zero");
    // readiness, pll and run requests
    a_ready_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        (osc_state.ready & ~$past(run)) == '0)
        else $error("ready shown for a stopped oscillator");
    a_pll_complete: assert property (@(posedge mclk) disable iff (!rst_n)
        (pll_enable && lock_s && requested_clock_source == OSET_SRC_FAST_PLL
            && ready_s[OSET_BIT_FAST-OSET_OSC_LSB]) |-> status[OSET_PLL_BIT])
        else $error("pll ready missing with source ready and locked");
    a_pll_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        pll_enable |-> (requested_clock_source == OSET_SRC_EXT_PLL
            || requested_clock_source == OSET_SRC_FAST_PLL))
        else $error("pll enabled for a source without pll");
    a_periph_runs: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && (|periph_req))
            |=> ((osc_state.run & $past(periph_req)) == $past(periph_req)))
        else $error("peripheral request not honoured");
    a_fast_source: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && requested_clock_source == OSET_SRC_FAST)
            |=> osc_state.run[OSET_BIT_FAST-OSET_OSC_LSB])
        else $error("fast oscillator not running as system source");
    // one run check per oscillator, whatever asked for it
    for (genvar k = 0; k < OSET_NUM_OSC; k++) begin : g_chk
        a_run_request: assert property (@(posedge mclk) disable iff (!rst_n)
            (rst_n && (force_q[k] || periph_req[k] || src_req[k])) |=> osc_state.run[k])
            else $error("requested oscillator not running");
    end
    // tune outputs and reset strap
    a_trim_out: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(trim_q) |=> tune.fast_trim == $past(trim_q))
        else $error("trim code not applied");
    a_power_low: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && !secondary_power_select) ##1 !secondary_power_select |-> !tune.sec_high_power)
        else $error("secondary low power mode wrong");
    a_strap_default: assert property (@(posedge mclk) disable iff (!rst_n)
        (rst_n && !strap_done_q && reset_clock_source_cfg != OSET_SRC_FAST_32M)
            |=> freq_q == OSET_FREQ_RST_1M)
        else $error("default reset frequency code not loaded");
    a_strap_once: assert property (@(posedge mclk) disable iff (!rst_n)
        strap_done_q |=> strap_done_q)
        else $error("reset strap sampled twice");
    // main scenarios
    c_write_force: cover property (@(posedge mclk) wr_lane0 && wb_adr_i == OSET_ADDR_FORCE);
    c_pll_ready: cover property (@(posedge mclk) status[OSET_PLL_BIT]);
    c_bad_addr: cover property (@(posedge mclk) wb_err_o);
    c_periph_only: cover property (@(posedge mclk) periph_req[0] && !force_q[0]);
    c_trim_write: cover property (@(posedge mclk) wr_lane0 && wb_adr_i == OSET_ADDR_TRIM);
endmodule // oset_top
`default_nettype wire

//--- hdl/oset_pkg.sv
// oset_pkg: register map, field layout, reset values, carriers for the oscillator control block
// assumes a classic wishbone slave with 32-bit data, registers one aligned word each
package oset_pkg;

    // register byte addresses on the wishbone bus
    localparam logic [3:0] OSET_ADDR_STATUS = 4'h0;
    localparam logic [3:0] OSET_ADDR_FORCE = 4'h4;
    localparam logic [3:0] OSET_ADDR_FREQ = 4'h8;
    localparam logic [3:0] OSET_ADDR_TRIM = 4'hC;
    localparam logic [3:0] OSET_ADDR_SRC = 4'h0;

    // oscillator index order: bit position minus the low bit
    localparam int OSET_NUM_OSC = 6;
    localparam int OSET_OSC_LSB = 2;
    localparam int OSET_PLL_BIT = 0;

    // force enable bit positions
    localparam int OSET_BIT_EXT = 7;
    localparam int OSET_BIT_FAST = 6;
    localparam int OSET_BIT_LOW = 4;
    localparam int OSET_BIT_SEC = 3;

    // reset values and masks
    localparam logic [7:0] OSET_FORCE_RST = 8'h00;
    localparam logic [7:0] OSET_FORCE_MASK = 8'hFC;
    localparam logic [5:0] OSET_TRIM_RST = 6'h20;
    localparam logic [2:0] OSET_FREQ_RSVD = 3'h7;
    localparam logic [2:0] OSET_FREQ_RST_1M = 3'h2;
    localparam logic [2:0] OSET_FREQ_RST_32M = 3'h6;
    localparam logic [2:0] OSET_SRC_FAST_1M = 3'h6;
    localparam logic [2:0] OSET_SRC_FAST_32M = 3'h0;
    localparam logic [2:0] OSET_SRC_FAST = 3'h6;
    localparam logic [2:0] OSET_SRC_FAST_PLL = 3'h1;
    localparam logic [2:0] OSET_SRC_EXT_PLL = 3'h2;
    localparam logic [2:0] OSET_SRC_EXT = 3'h7;
    localparam logic [2:0] OSET_SRC_LOW = 3'h5;
    localparam logic [2:0] OSET_SRC_SEC = 3'h4;

    // nominal frequency code table entries
    typedef enum logic [2:0] {
        OSET_F1M = 3'b000,
        OSET_F2M = 3'b001,
        OSET_F4M = 3'b010,
        OSET_F8M = 3'b011,
        OSET_F12M = 3'b100,
        OSET_F16M = 3'b101,
        OSET_F32M = 3'b110,
        OSET_FRSV = 3'b111
    } oset_freq_t;

    // per oscillator request and ready levels travel together
    typedef struct packed {
        logic [OSET_NUM_OSC-1:0] run;
        logic [OSET_NUM_OSC-1:0] ready;
    } oset_osc_t;

    // settings that go to the analog oscillator macros
    typedef struct packed {
        logic [2:0] ext_mode;
        logic sec_high_power;
        oset_freq_t fast_freq;
        logic [5:0] fast_trim;
    } oset_tune_t;

endpackage : oset_pkg

//--- hdl/oset_sync.sv
// oset_sync: two flip-flop synchroniser for a bus of asynchronous levels
// assumes inputs come from oscillator macros outside the mclk domain
`timescale 1ns/1ps
`default_nettype none
module oset_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // oset_sync
`default_nettype wire

//--- hdl/oset_req.sv
// oset_req: per oscillator run request, an OR of manual, peripheral and clock source asks
// assumes all inputs are already in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module oset_req (
    // request sources
    input wire logic [oset_pkg::OSET_NUM_OSC-1:0] force_on,
    input wire logic [oset_pkg::OSET_NUM_OSC-1:0] periph_req,
    input wire logic [oset_pkg::OSET_NUM_OSC-1:0] src_req,
    // combined request
    output logic [oset_pkg::OSET_NUM_OSC-1:0] run
);
    import oset_pkg::*;

    // one term per oscillator; clear manual bit never forces off
    for (genvar i = 0; i < OSET_NUM_OSC; i++) begin : g_req
        assign run[i] = force_on[i] | periph_req[i] | src_req[i];
    end
endmodule // oset_req
`default_nettype wire

//--- testbench/testbench.sv
// testbench: self-checking bench for oset_top, registers reached over classic wishbone
// assumes oset_pkg and the design files are compiled first; assertions sit in the design files
`timescale 1ns/1ps
`default_nettype none
module testbench;
import oset_pkg::*;
////////////////////////////////////////////////////////////////////////////////
// stimulus and observed signals, named as the ports so they connect by name
logic mclk = 1'b0;
logic rst_n = 1'b0;
logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
logic wb_ack_o, wb_err_o;
logic [2:0] reset_clock_source_cfg = 3'h0, external_osc_mode_cfg = 3'h0;
logic [2:0] requested_clock_source = 3'h4;
logic secondary_power_select = 1'b0, pll_lock_async = 1'b0, pll_enable;
logic [OSET_NUM_OSC-1:0] periph_req = '0, osc_ready_async = '0;
oset_osc_t osc_state;
oset_tune_t tune;
int fail_count = 0;
int total_checks = 0;
logic [31:0] rd;
logic er;
// free running 100 MHz clock
always #5 mclk = ~mclk;
oset_top uut (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .reset_clock_source_cfg,
    .external_osc_mode_cfg, .requested_clock_source, .secondary_power_select,
    .periph_req, .osc_ready_async, .pll_lock_async, .osc_state, .pll_enable, .tune);
////////////////////////////////////////////////////////////////////////////////
// compare, count, report at once
task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
endtask
// single exit point of the run
task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
// one classic cycle; the request stands until ack or err is sampled high
task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat,
    input logic [3:0] sel);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, dat};
    for (n = 0; n < 20; n++) begin
        @(posedge mclk);
        if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (n == 20) begin
        fail_count++;
        results();
    end
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
endtask
task automatic wr(input logic [3:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 4'hF);
    // one more edge: outputs registered from the new value show only after it
    @(posedge mclk);
endtask
task automatic rdchk(input string what, input logic [3:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, 4'hF);
    chk(what, rd, {24'h0, exp});
endtask
// reset held six cycles with the given strap
task automatic t_reset(input logic [2:0] cfg, input logic [7:0] freq);
    @(posedge mclk);
    rst_n <= 1'b0;
    reset_clock_source_cfg <= cfg;
    // macros report nothing ready, so the status reset value is what shows
    osc_ready_async <= '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("force reset", OSET_ADDR_FORCE, 8'h00);
    rdchk("freq reset", OSET_ADDR_FREQ, freq);
    rdchk("trim reset", OSET_ADDR_TRIM, 8'h20);
    rdchk("status reset", OSET_ADDR_STATUS, 8'h00);
    chk("tune trim", {26'h0, tune.fast_trim}, 32'h20);
    $display("test reset done");
endtask
// each force bit alone, then readiness, peripheral and source requests
task automatic t_force();
    int i;
    osc_ready_async <= '1;
    for (i = 2; i < 8; i++) begin
        wr(OSET_ADDR_FORCE, 8'h01 << i);
        chk("run one", {26'h0, osc_state.run}, 32'h02 | (32'h1 << (i - 2)));
    end
    wr(OSET_ADDR_FORCE, 8'hFF);
    rdchk("force rd", OSET_ADDR_FORCE, 8'hFC);
    chk("run all", {26'h0, osc_state.run}, 32'h3F);
    repeat (4) @(posedge mclk);
    rdchk("status all", OSET_ADDR_STATUS, 8'hFC);
    wr(OSET_ADDR_STATUS, 8'h00);
    rdchk("status ro", OSET_ADDR_STATUS, 8'hFC);
    periph_req <= 6'h01;
    wr(OSET_ADDR_FORCE, 8'h00);
    chk("run left", {26'h0, osc_state.run}, 32'h03);
    rdchk("status left", OSET_ADDR_STATUS, 8'h0C);
    chk("ready left", {26'h0, osc_state.ready}, 32'h03);
    bus(1'b1, OSET_ADDR_FORCE, 8'hFC, 4'h0);
    rdchk("force no lane", OSET_ADDR_FORCE, 8'h00);
    periph_req <= 6'h00;
    $display("test force done");
endtask
// every frequency code, trim limits, unused bits read 0
task automatic t_tune();
    int c;
    for (c = 0; c < 8; c++) begin
        wr(OSET_ADDR_FREQ, 8'(c) | 8'hF8);
        rdchk("freq rd", OSET_ADDR_FREQ, 8'(c));
        chk("tune freq", {29'h0, tune.fast_freq}, 32'(c));
    end
    wr(OSET_ADDR_TRIM, 8'hFF);
    rdchk("trim max", OSET_ADDR_TRIM, 8'h3F);
    chk("tune trim max", {26'h0, tune.fast_trim}, 32'h3F);
    wr(OSET_ADDR_TRIM, 8'h00);
    chk("tune trim min", {26'h0, tune.fast_trim}, 32'h00);
    external_osc_mode_cfg <= 3'h5;
    secondary_power_select <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("ext mode", {29'h0, tune.ext_mode}, 32'h5);
    chk("sec power hi", {31'h0, tune.sec_high_power}, 32'h1);
    secondary_power_select <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("sec power lo", {31'h0, tune.sec_high_power}, 32'h0);
    $display("test tune done");
endtask
// pll ready needs enable, source ready and lock together
task automatic t_pll();
    requested_clock_source <= OSET_SRC_FAST_PLL;
    pll_lock_async <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("pll en", {31'h0, pll_enable}, 32'h1);
    rdchk("pll ready", OSET_ADDR_STATUS, 8'h41);
    pll_lock_async <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk("pll unlocked", OSET_ADDR_STATUS, 8'h40);
    pll_lock_async <= 1'b1;
    osc_ready_async <= 6'h2F;
    repeat (4) @(posedge mclk);
    rdchk("pll src slow", OSET_ADDR_STATUS, 8'h00);
    osc_ready_async <= '1;
    requested_clock_source <= OSET_SRC_FAST;
    repeat (4) @(posedge mclk);
    chk("pll off", {31'h0, pll_enable}, 32'h0);
    rdchk("pll not en", OSET_ADDR_STATUS, 8'h40);
    $display("test pll done");
endtask
// unmapped places answer with err and change nothing
task automatic t_err();
    wr(4'h5, 8'hFC);
    chk("err wr", {31'h0, er}, 32'h1);
    bus(1'b0, 4'h1, 8'h00, 4'hF);
    chk("err rd", {31'h0, er}, 32'h1);
    rdchk("force kept", OSET_ADDR_FORCE, 8'h00);
    wr(OSET_ADDR_FORCE, 8'h84);
    $display("test err done");
endtask
////////////////////////////////////////////////////////////////////////////////
// main sequence; the second reset lands with force bits set
initial begin
    t_reset(OSET_SRC_FAST_32M, 8'h06);
    t_force();
    t_tune();
    t_pll();
    t_err();
    t_reset(OSET_SRC_FAST_1M, 8'h02);
    results();
end
endmodule // testbench
`default_nettype wire
